// file: hw/lasc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module lasc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [PW:0]      next_count;
  logic             doPush;
  logic             doPop;

  // honest flags: full blocks the source, empty blocks the drain
  assign inReady  = (count != DEPTH[PW:0]);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // pointer and fill-level next values
  always_comb begin
    next_wrPtr = doPush ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doPop ? rdPtr + 1'b1 : rdPtr;
    next_count = count;
    if (doPush & ~doPop) begin
      next_count = count + 1'b1;
    end else if (doPop & ~doPush) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage carries no reset, it is qualified by count
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule
`default_nettype wire

// file: hw/lasc_pkg.sv
package lasc_pkg;

  // sample word width and read-out buffer depth
  localparam int SAMPLE_W   = 12;
  localparam int FIFO_DEPTH = 8;

  // core clock, for reference by timing users
  localparam int CORE_CLK_PERIOD_NS = 100;

  // half-step counting: falling edge k of the sensor clock is step 2k,
  // the rising edge that follows it is step 2k+1
  localparam logic [11:0] HALF_FIRST_FALL  = 12'h002; // clock 1
  localparam logic [11:0] HALF_FIRST_CHAN  = 12'h025; // clock 18.5
  localparam logic [11:0] HALF_SLAVE_ENTRY = 12'h022; // clock 17
  localparam logic [2:0]  SLOT_PHASE_VIDEO = 3'h0;    // new channel
  localparam logic [2:0]  TRIG_PHASE_RISE  = 3'h2;    // clock 19.5 + 4n
  localparam logic [2:0]  TRIG_PHASE_FALL  = 3'h4;
  localparam logic [11:0] EOS_LEAD_HALF    = 12'h004; // eos before end
  localparam logic [11:0] EOS_TAIL_HALF    = 12'h004; // eos after end

  // integration starts and stops on this falling edge after reset moves
  localparam logic [3:0] INT_DELAY_FALLS = 4'h8;

  // channel count straps and their counts
  localparam logic [1:0] CHAN_SEL_64  = 2'h0;
  localparam logic [1:0] CHAN_SEL_128 = 2'h1;
  localparam logic [1:0] CHAN_SEL_256 = 2'h2;
  localparam logic [8:0] CHAN_CNT_64  = 9'h040;
  localparam logic [8:0] CHAN_CNT_128 = 9'h080;
  localparam logic [8:0] CHAN_CNT_256 = 9'h100;

  // read-out sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SCAN = 3'b100
  } lasc_state_type;

endpackage

// file: hw/lasc_top.sv
// What this block does
// RULE1: timing starts on first sensor clock fall after reset goes low
// RULE2: first channel video valid from clock 18.5 through clock 20.5
// RULE3: each later channel appears exactly 4 clocks after the previous one
// RULE4: trigger rises at clock 19.5, then every 4 clocks per channel
// RULE5: controller captures video on the trigger rising edge
// RULE6: integration length equals the reset high time
// RULE7: integration runs from 8th fall after reset rise to 8th after fall
// RULE8: after reset falls, integrated channels shift out in order
// RULE9: controller moves reset only on sensor clock rising edges
// RULE10: controller never raises reset during video output
// RULE11: controller keeps each reset period at least 16.5 + 4N clocks
// RULE12: after end of scan the video output goes high impedance
// RULE13: video sample rate is one quarter of the sensor clock
// RULE14: controller keeps video rate at or below 1 MHz
// RULE15: scan covers 64, 128 or 256 channels by variant
// RULE16: all elements integrate together before sequential read-out
// RULE17: stage select low for later chained arrays, high otherwise
// RULE18: later array scan start driven by previous end of scan
// RULE19: chained arrays share clock and reset, videos tied together
// RULE20: gain select high means high gain, low means low gain
// RULE21: end of scan pulses low once after the last channel slot; here it falls 2 clocks before that slot ends
// RULE22: slave stage starts read-out on a scan start pulse
`timescale 1ns/1ns
`default_nettype none
module lasc_top (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  // controller pins, synchronous to core_clk
  input  wire logic                         sensorClk,
  input  wire logic                         resetPulse,
  input  wire logic                         stageSelect,
  input  wire logic                         scanStartIn,
  input  wire logic [1:0]                   channelCountSel,
  // held charge samples from the amplifier bank
  input  wire logic [lasc_pkg::SAMPLE_W-1:0] sampleData,
  input  wire logic                         sampleValid,
  output logic                              sampleReady,
  // video and strobes
  output logic [lasc_pkg::SAMPLE_W-1:0]     videoData,
  output logic                              videoOe,
  output logic                              trigger,
  output logic                              scanEndOutN,
  // status
  output logic                              integrating,
  output logic                              scanActive
);
  localparam int SW = lasc_pkg::SAMPLE_W;

  // edge history of the controller pins
  logic sensorClkPrev;
  logic resetPrev;
  logic clkFall;
  logic clkRise;
  logic resetRise;
  logic resetFall;

  // integration window tracking
  logic       intCountOn;
  logic       intTarget;
  logic [3:0] intCnt;
  logic       next_intCountOn;
  logic       next_intTarget;
  logic [3:0] next_intCnt;
  logic       next_integrating;

  // read-out sequencer
  lasc_pkg::lasc_state_type state;
  lasc_pkg::lasc_state_type next_state;
  logic          startPending;
  logic          next_startPending;
  logic [11:0]   halfCnt;
  logic [11:0]   next_halfCnt;
  logic [SW-1:0] next_videoData;
  logic          next_videoOe;
  logic          next_trigger;
  logic          next_scanEndOutN;
  logic [8:0]    chanCount;
  logic [8:0]    next_chanCount;

  // slot arithmetic and buffer drain
  logic [11:0]   rel;
  logic [11:0]   endRel;
  logic [11:0]   stepHalf;
  logic          slotStep;
  logic          fifoPop;
  logic          fifoValid;
  logic [SW-1:0] fifoData;

  assign clkFall   = sensorClkPrev & ~sensorClk;
  assign clkRise   = ~sensorClkPrev & sensorClk;
  assign resetRise = resetPulse & ~resetPrev;  // [RULE9]
  assign resetFall = ~resetPulse & resetPrev;
  assign scanActive = (state == lasc_pkg::ST_SCAN);

  // buffer between the amplifier bank and the video slots; a slow scan
  // stalls the bank through sampleReady once eight words are waiting
  lasc_fifo #(
    .WIDTH (SW),
    .DEPTH (lasc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // integration window: counts sensor clock falls after each reset edge
  always_comb begin
    next_intCountOn  = intCountOn;
    next_intTarget   = intTarget;
    next_intCnt      = intCnt;
    next_integrating = integrating;
    if (resetRise | resetFall) begin
      next_intCountOn = 1'b1;
      next_intTarget  = resetRise;
      next_intCnt     = 4'h0;
    end else if (clkFall & intCountOn) begin
      next_intCnt = intCnt + 4'h1;
      if (intCnt + 4'h1 == lasc_pkg::INT_DELAY_FALLS) begin
        // one flag gates every element at once [RULE16] [RULE6] [RULE7]
        next_integrating = intTarget;
        next_intCountOn  = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // follow the pins in reset so release never shows a false edge
      sensorClkPrev <= sensorClk;
      resetPrev     <= resetPulse;
      intCountOn    <= 1'b0;
      intTarget     <= 1'b0;
      intCnt        <= 4'h0;
      integrating   <= 1'b0;
    end else begin
      sensorClkPrev <= sensorClk;
      resetPrev     <= resetPulse;
      intCountOn    <= next_intCountOn;
      intTarget     <= next_intTarget;
      intCnt        <= next_intCnt;
      integrating   <= next_integrating;
    end
  end

  // channel count is a strap, caught while the block is held in reset
  always_comb begin
    case (channelCountSel)
      lasc_pkg::CHAN_SEL_128: next_chanCount = lasc_pkg::CHAN_CNT_128;
      lasc_pkg::CHAN_SEL_256: next_chanCount = lasc_pkg::CHAN_CNT_256;
      default:                next_chanCount = lasc_pkg::CHAN_CNT_64;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      chanCount <= next_chanCount;  // [RULE15]
    end
  end

  // slot position relative to the first channel's video edge; built on
  // the registered count so nothing loops back through next_halfCnt
  assign slotStep = (clkFall | clkRise) & (state == lasc_pkg::ST_SCAN);
  assign stepHalf = halfCnt + 12'h001;
  assign rel      = stepHalf - lasc_pkg::HALF_FIRST_CHAN;
  assign endRel   = {chanCount, 3'h0};
  assign fifoPop  = slotStep & (stepHalf >= lasc_pkg::HALF_FIRST_CHAN)
                    & (rel[2:0] == lasc_pkg::SLOT_PHASE_VIDEO)
                    & (rel < endRel);

  // sequencer next values
  always_comb begin
    next_state        = state;
    next_startPending = startPending;
    next_halfCnt      = halfCnt;
    next_videoData    = videoData;
    next_videoOe      = videoOe;
    next_trigger      = trigger;
    next_scanEndOutN  = scanEndOutN;
    case (state)
      lasc_pkg::ST_IDLE: begin
        if (clkFall & startPending) begin
          next_startPending = 1'b0;
          if (stageSelect) begin
            next_state   = lasc_pkg::ST_SCAN;  // [RULE1]
            next_halfCnt = lasc_pkg::HALF_FIRST_FALL;
          end else begin
            next_state = lasc_pkg::ST_WAIT;  // [RULE17]
          end
        end
      end
      lasc_pkg::ST_WAIT: begin
        // entry lines our first video edge up with the upstream release
        if (clkFall & ~scanStartIn) begin
          next_state   = lasc_pkg::ST_SCAN;  // [RULE22] [RULE18]
          next_halfCnt = lasc_pkg::HALF_SLAVE_ENTRY;
        end
      end
      lasc_pkg::ST_SCAN: begin
        if (slotStep) begin
          next_halfCnt = stepHalf;
        end
        if (fifoPop) begin
          // new channel every 8 half steps, one per 4 clocks
          // [RULE2] [RULE3] [RULE13]
          next_videoData = fifoValid ? fifoData : '0;
          next_videoOe   = 1'b1;
        end
        if (slotStep & (stepHalf >= lasc_pkg::HALF_FIRST_CHAN)
            & (rel < endRel)) begin
          if (rel[2:0] == lasc_pkg::TRIG_PHASE_RISE) begin
            next_trigger = 1'b1;  // [RULE4]
          end else if (rel[2:0] == lasc_pkg::TRIG_PHASE_FALL) begin
            next_trigger = 1'b0;
          end
        end
        if (slotStep & (rel == endRel - lasc_pkg::EOS_LEAD_HALF)) begin
          next_scanEndOutN = 1'b0;  // [RULE21]
        end
        if (slotStep & (rel == endRel)) begin
          next_videoOe = 1'b0;  // release the shared line [RULE12]
          next_trigger = 1'b0;
        end
        if (slotStep & (rel == endRel + lasc_pkg::EOS_TAIL_HALF)) begin
          next_scanEndOutN = 1'b1;  // [RULE21]
          next_state       = lasc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = lasc_pkg::ST_IDLE;
      end
    endcase
    // a new start outranks the idle clear of the same cycle
    if (resetFall) begin
      next_startPending = 1'b1;  // [RULE8]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state        <= lasc_pkg::ST_IDLE;
      startPending <= 1'b0;
      halfCnt      <= 12'h000;
      videoData    <= '0;
      videoOe      <= 1'b0;
      trigger      <= 1'b0;
      scanEndOutN  <= 1'b1;
    end else begin
      state        <= next_state;
      startPending <= next_startPending;
      halfCnt      <= next_halfCnt;
      videoData    <= next_videoData;
      videoOe      <= next_videoOe;
      trigger      <= next_trigger;
      scanEndOutN  <= next_scanEndOutN;
    end
  end
endmodule
`default_nettype wire

// file: verification/lasc_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module lasc_ctrl_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // exposure request from the bench
  input  wire logic req,
  // pins toward the array
  output var logic  sensorClk,
  output var logic  resetPulse
);
  logic [1:0] div = 2'h0;

  // the gain strap only scales analog levels; the model has no gain pin
  // and no digital path reads it

  initial begin
    sensorClk = 1'b0;
    resetPulse = 1'b0;
  end

  // clock runs free at core_clk / 8, so video stays at 312.5 kHz
  always @(posedge core_clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      sensorClk <= #1 ~sensorClk;
      // exposure length is the request time, moved only on a rise
      if (!sensorClk) begin
        resetPulse <= #1 req & ~srst;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/lasc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lasc_top_asserts (
  // clock and reset
  input wire logic                          core_clk,
  input wire logic                          srst,
  // controller pins
  input wire logic                          sensorClk,
  input wire logic                          resetPulse,
  input wire logic                          stageSelect,
  input wire logic [1:0]                    channelCountSel,
  // video, strobes and status
  input wire logic [lasc_pkg::SAMPLE_W-1:0] videoData,
  input wire logic                          videoOe,
  input wire logic                          trigger,
  input wire logic                          scanEndOutN,
  input wire logic                          integrating,
  input wire logic                          scanActive
);
  logic       sPrev, rPrev, tPrev, trigSeen;
  logic [4:0] riseFalls, startFalls, trigFalls;
  logic [8:0] trigCnt, chanCnt;
  wire logic  fall;
  wire logic  trigRise;

  // edge pulses from the previous samples
  assign fall     = sPrev & ~sensorClk;
  assign trigRise = trigger & ~tPrev;

  // saturating fall counter, so long exposures never wrap
  function automatic logic [4:0] inc(logic [4:0] c);
    return c + {4'h0, fall & ~&c};
  endfunction

  // sensor falls since each reset edge and since the last trigger
  always_ff @(posedge core_clk) begin
    sPrev <= sensorClk;
    rPrev <= resetPulse;
    tPrev <= trigger;
    if (srst) begin
      riseFalls  <= 5'h00;
      startFalls <= 5'h00;
      trigFalls  <= 5'h00;
      trigSeen   <= 1'b0;
      trigCnt    <= 9'h000;
      chanCnt    <= (channelCountSel == lasc_pkg::CHAN_SEL_128) ?
                    lasc_pkg::CHAN_CNT_128 :
                    (channelCountSel == lasc_pkg::CHAN_SEL_256) ?
                    lasc_pkg::CHAN_CNT_256 : lasc_pkg::CHAN_CNT_64;
    end else begin
      riseFalls  <= (resetPulse & ~rPrev) ? 5'h00 : inc(riseFalls);
      startFalls <= (rPrev & ~resetPulse) ? 5'h00 : inc(startFalls);
      trigFalls  <= trigRise ? 5'h00 : inc(trigFalls);
      trigSeen   <= scanActive & (trigSeen | trigRise);
      trigCnt    <= scanActive ? trigCnt + {8'h00, trigRise} : 9'h000;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_INT_START:
    assert property ($rose(integrating) |-> riseFalls == 5'h08)
    else $error("integration began on the wrong fall");
  AST_INT_END:
    assert property ($fell(integrating) |-> startFalls == 5'h08)
    else $error("integration ended on the wrong fall");
  AST_VIDEO_START:
    assert property ($rose(videoOe) && stageSelect |-> startFalls == 5'h12)
    else $error("first channel at the wrong clock");
  AST_FIRST_TRIG:
    assert property ($rose(trigger) && !trigSeen && stageSelect
                     |-> startFalls == 5'h13)
    else $error("first trigger at the wrong clock");
  AST_TRIG_GAP:
    assert property ($rose(trigger) && trigSeen |-> trigFalls == 5'h04)
    else $error("channel spacing is not four clocks");
  AST_TRIG_VIDEO:
    assert property (trigger |-> videoOe && $stable(videoData))
    else $error("video moved while the trigger was high");
  AST_EOS_COUNT:
    assert property ($fell(scanEndOutN) |-> trigCnt == chanCnt)
    else $error("end of scan after the wrong channel count");
  AST_OE_EOS:
    assert property ($fell(videoOe) |-> !scanEndOutN)
    else $error("video released outside end of scan");
  AST_HIZ:
    assert property ($rose(scanEndOutN) |-> !videoOe)
    else $error("video still driven after end of scan");
endmodule
bind lasc_top lasc_top_asserts lasc_top_asserts_i (.*);
`default_nettype wire

// file: verification/lasc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lasc_top_tb;
  logic                          core_clk = 1'b0;
  logic                          srst = 1'b1;
  logic                          req = 1'b0;
  logic                          stageSelect = 1'b1;
  logic                          scanStartIn = 1'b1;
  logic [1:0]                    channelCountSel = 2'h0;
  logic [lasc_pkg::SAMPLE_W-1:0] sampleData = '0;
  logic                          sampleValid = 1'b0;
  logic [lasc_pkg::SAMPLE_W-1:0] videoData;
  logic [lasc_pkg::SAMPLE_W-1:0] expQ[$];
  logic [lasc_pkg::SAMPLE_W-1:0] expV;
  logic                          sensorClk, resetPulse, sampleReady;
  logic                          videoOe, trigger, scanEndOutN;
  logic                          integrating, scanActive;
  logic                          tPrev = 1'b0;
  int                            fails = 0;
  int                            check_count = 0;
  int                            trigCount = 0;
  int                            cycles = 0;
  int                            seed = 32'hB5F5;
  int                            r;

  always #50 core_clk = ~core_clk;

  lasc_top lasc_top_i (.*);
  lasc_ctrl_model lasc_ctrl_model_i (.*); // shared clock, reset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic compare_data(string w, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", w, e, g);
    end
  endtask

  task automatic compare_count(string w, int e, int g);
    check_count++;
    if (g != e) begin
      fails++;
      $display("[ERR] %s exp %0d got %0d", w, e, g);
    end
  endtask

  task automatic compare_flag(string w, logic e, logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", w, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // watchdog: a hang counts as a mismatch and still reaches the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end

  // amplifier bank: random words, held until taken; note each taken one
  always @(posedge core_clk) begin
    if (!srst && sampleValid && sampleReady) expQ.push_back(sampleData);
    if (srst || !sampleValid || sampleReady) begin
      #1 r = $random(seed);
      sampleValid = r[13:12] != 2'h0;
      sampleData = r[lasc_pkg::SAMPLE_W-1:0];
    end
  end

  // controller capture on each trigger rise; empty buffer reads zero
  always @(posedge core_clk) begin
    tPrev <= trigger;
    if (!srst && trigger === 1'b1 && tPrev === 1'b0) begin
      trigCount++;
      expV = expQ.size() ? expQ.pop_front() : '0;
      compare_data("video", expV, videoData);
    end
  end

  // one exposure and read-out; the next exposure waits for end of scan
  task automatic run_scan(logic [1:0] sel, int n, logic master);
    int t;
    tick(1);
    srst = 1'b1;
    channelCountSel = sel;
    stageSelect = master;
    expQ.delete();
    tick(8);
    srst = 1'b0;
    trigCount = 0;
    req = 1'b1;
    tick(192);
    compare_flag("integrating", 1'b1, integrating);
    req = 1'b0;
    if (!master) begin
      tick(320);
      compare_count("idle slave", 0, trigCount);
      compare_flag("slave wait", 1'b0, scanActive);
      scanStartIn = 1'b0;
      tick(8);
      scanStartIn = 1'b1;
    end
    t = 0;
    while (scanEndOutN !== 1'b0 && t < 12000) begin
      tick(1);
      t++;
    end
    compare_flag("end of scan low", 1'b0, scanEndOutN);
    tick(64);
    compare_count("channels", n, trigCount);
    compare_flag("video drive", 1'b0, videoOe);
    compare_flag("end of scan release", 1'b1, scanEndOutN);
    compare_flag("scan active", 1'b0, scanActive);
    compare_flag("integrating", 1'b0, integrating);
    $display("scan of %0d channels, master %b, done", n, master);
  endtask

  initial begin
    run_scan(2'h0, 64, 1'b1);
    run_scan(2'h1, 128, 1'b1);
    run_scan(2'h2, 256, 1'b1);
    run_scan(2'h3, 64, 1'b1);
    run_scan(2'h0, 64, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
